// file: rtl/pic_pkg.sv
// Constants, types and shared functions of the interrupt controller.
// Assumes one instruction clock and an active high asynchronous reset.
package pic_pkg;
   localparam int unsigned NUM_SRC = 8;
   localparam int unsigned NUM_TRAP_SLOTS = 8;
   localparam int unsigned NUM_TRAP_IMPL = 4;
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_ALL_MASK = 3'h7;
   localparam logic [7:0] STAT_MASK_OR = 8'h0E;
   localparam int unsigned NEST_DIS_BIT = 15;
   localparam int unsigned LATENCY_TCY = 5;
   localparam logic [2:0] LATENCY_CNT = 3'(LATENCY_TCY - 1);
   localparam int unsigned CPL_STACK_DEPTH = 16;
   localparam logic [2:0] TDIS_LO = 3'h1;
   localparam logic [2:0] TDIS_HI = 3'h6;
   localparam logic [3:0] TRAP_BASE_LVL = 4'h8;
   localparam logic [15:0] PRI_VEC_BASE = 16'h0004;
   localparam logic [15:0] ALT_VEC_BASE = 16'h0104;
   localparam logic [15:0] USER_VEC_OFS = 16'h0010;

   typedef enum logic [2:0] {
      PIC_TRAP_ADDR,
      PIC_TRAP_OSC,
      PIC_TRAP_STACK,
      PIC_TRAP_MATH
   } pic_trap_t;

   // Vector address for slot n in the selected table
   function automatic logic [15:0] pic_vec(input logic alt,
                                          input logic [15:0] slot);
      pic_vec = (alt ? ALT_VEC_BASE : PRI_VEC_BASE) + slot;
   endfunction : pic_vec
endpackage : pic_pkg

// file: rtl/pic_if.sv
// Link between the interrupt controller and the processor core.
// Assumes both ends run on the same instruction clock.
`timescale 1ns/1ps
interface pic_if;
   logic vec_req;
   logic [15:0] vec_addr;
   logic [3:0] vec_level;
   logic hard_hold;
   logic wake;
   logic vec_ack;
   logic irq_return;
   logic [2:0] cpu_level;
   logic cpl_write;
   logic [2:0] cpl_wdata;
   logic tdis_start;
   logic [13:0] tdis_count;
   logic sleeping;
   modport ctrl (output vec_req, vec_addr, vec_level, hard_hold, wake,
      cpu_level, input vec_ack, irq_return, cpl_write, cpl_wdata,
      tdis_start, tdis_count, sleeping);
   modport core (input vec_req, vec_addr, vec_level, hard_hold, wake,
      cpu_level, output vec_ack, irq_return, cpl_write, cpl_wdata,
      tdis_start, tdis_count, sleeping);
endinterface : pic_if

// file: rtl/pic_ctrl.sv
// Prioritised interrupt controller with traps, nesting and timed disable.
// Assumes peripheral events and core strobes are synchronous to ref_clk.
// Function
// - Each source has enable, flag, priority
// - User priority overrides natural order
// - Only requests above CPU level pass
// - Nesting preempts unless nesting_disable set
// - Fixed five cycle latency to vectoring
// - Four traps that cannot be masked
// - Traps 2-7 vector to their own vector, hard traps do not
// - Hard traps hold core until cleared
// - Each trap has its own flag
// - Room for four more trap sources
// - Users 0-7, traps 8-15
// - Priority fields reset to four
// - Wake resumes or vectors by level
// - Level seven blocks all user requests
// - Timed disable blocks levels one to six
// - Return restores previous CPU level
// - Handler clears flag before return
// - Clear flag, then set enable
// - Primary or alternate vector table
// - Flat priority uses one non-zero value
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module pic_ctrl #(
   parameter int unsigned NSRC = pic_pkg::NUM_SRC
) (
   input wire logic ref_clk, // Instruction clock
   input wire logic rst, // Async reset, active high
   pic_if.ctrl cpu, // Core side
   input wire logic [NSRC-1:0] src_event, // Peripheral event pulses
   input wire logic [pic_pkg::NUM_TRAP_SLOTS-1:0] trap_event, // Trap pulses
   input wire logic [NSRC-1:0] src_enable_bit, // Per source enable
   input wire logic [3*NSRC-1:0] prio_wdata, // Priority fields to load
   input wire logic prio_we, // Load all priority fields
   input wire logic [NSRC-1:0] flag_clr, // Clear pending flags
   input wire logic [pic_pkg::NUM_TRAP_SLOTS-1:0] trap_clr, // Clear traps
   input wire logic [15:0] irq_control_one, // Control word
   input wire logic alt_table_sel, // Use alternate vector table
   output logic [NSRC-1:0] source_pending_flag, // Pending flags
   output logic [pic_pkg::NUM_TRAP_SLOTS-1:0] trap_flag_q, // Trap flags
   output logic [3*NSRC-1:0] source_priority_field // Priority readback
);
   logic [NSRC-1:0] flag_q;
   logic [2:0] prio_q [NSRC];
   logic [pic_pkg::NUM_TRAP_SLOTS-1:0] trap_q;
   logic [2:0] cpl_q;
   logic [2:0] cpl_stack_q [pic_pkg::CPL_STACK_DEPTH];
   logic [3:0] sp_q;
   logic [3:0] active_lvl_q;
   logic in_isr_q;
   logic [13:0] tdis_q;
   logic [2:0] lat_q;
   logic pend_q;
   logic [15:0] pend_vec_q;
   logic [3:0] pend_lvl_q;
   logic vec_req_q;
   logic [15:0] vec_addr_q;
   logic [3:0] vec_level_q;
   logic hard_q;
   logic wake_q;
   logic [2:0] best_lvl;
   logic [15:0] best_slot;
   logic best_ok;
   logic [2:0] trap_idx;
   logic trap_any;
   logic [3:0] trap_lvl;
   logic [pic_pkg::NUM_TRAP_SLOTS-1:0] trap_d;
   logic nest_dis;

   assign nest_dis = irq_control_one[pic_pkg::NEST_DIS_BIT];
   assign source_pending_flag = flag_q;
   assign trap_flag_q = trap_q;
   assign trap_d = (trap_q & ~trap_clr) | trap_event;

   always_comb
   begin
      for (int i = 0; i < NSRC; i++)
         source_priority_field[3*i +: 3] = prio_q[i];
   end

   // Flags: a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         flag_q <= '0;
      else
         flag_q <= (flag_q & ~flag_clr) | src_event;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         trap_q <= '0;
      else
         trap_q <= trap_d;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NSRC; i++)
            prio_q[i] <= pic_pkg::PRIO_RESET;
      end
      else if (prio_we)
      begin
         for (int i = 0; i < NSRC; i++)
            prio_q[i] <= prio_wdata[3*i +: 3];
      end
   end

   // Highest user level wins; lower index breaks ties
   always_comb
   begin
      best_lvl = '0;
      best_slot = '0;
      best_ok = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (flag_q[i] && src_enable_bit[i] && prio_q[i] != 3'h0
             && prio_q[i] >= best_lvl)
         begin
            best_lvl = prio_q[i];
            best_slot = 16'(i);
            best_ok = 1'b1;
         end
      end
      // Timed disable holds off levels one to six only
      if (tdis_q != '0 && best_lvl >= pic_pkg::TDIS_LO
          && best_lvl <= pic_pkg::TDIS_HI)
         best_ok = 1'b0;
      if (best_lvl <= cpl_q)
         best_ok = 1'b0;
      if (in_isr_q && (nest_dis || {1'b0, best_lvl} <= active_lvl_q))
         best_ok = 1'b0;
   end

   // Lowest trap index is most serious; traps always outrank users
   always_comb
   begin
      trap_idx = '0;
      trap_any = 1'b0;
      for (int i = pic_pkg::NUM_TRAP_SLOTS - 1; i >= 0; i--)
      begin
         if (trap_q[i])
         begin
            trap_idx = 3'(i);
            trap_any = 1'b1;
         end
      end
      trap_lvl = pic_pkg::TRAP_BASE_LVL + 4'(7 - trap_idx);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         tdis_q <= '0;
      else if (cpu.tdis_start)
         tdis_q <= cpu.tdis_count;
      else if (tdis_q != '0)
         tdis_q <= tdis_q - 14'h0001;
   end

   // Latency pipeline, traps bypass it
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pend_q <= 1'b0;
         lat_q <= '0;
         pend_vec_q <= '0;
         pend_lvl_q <= '0;
      end
      else if (cpu.vec_ack)
         pend_q <= 1'b0;
      else if (!pend_q && !vec_req_q && best_ok && !trap_any)
      begin
         pend_q <= 1'b1;
         lat_q <= pic_pkg::LATENCY_CNT;
         pend_vec_q <= pic_pkg::pic_vec(alt_table_sel,
            pic_pkg::USER_VEC_OFS + best_slot);
         pend_lvl_q <= {1'b0, best_lvl};
      end
      else if (pend_q && lat_q != '0)
         lat_q <= lat_q - 3'h1;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         vec_req_q <= 1'b0;
         vec_addr_q <= '0;
         vec_level_q <= '0;
      end
      else if (cpu.vec_ack)
         vec_req_q <= 1'b0;
      // A trap may replace a waiting user vector, and nests only above
      // the running handler, so a taken trap is not raised again
      else if (trap_any && !hard_q && (!vec_req_q || !vec_level_q[3])
               && (!in_isr_q || trap_lvl > active_lvl_q))
      begin
         vec_req_q <= 1'b1;
         vec_addr_q <= pic_pkg::pic_vec(alt_table_sel, 16'(trap_idx));
         vec_level_q <= trap_lvl;
      end
      else if (pend_q && lat_q == '0 && !vec_req_q && !hard_q)
      begin
         vec_req_q <= 1'b1;
         vec_addr_q <= pend_vec_q;
         vec_level_q <= pend_lvl_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         hard_q <= 1'b0;
      else
         // From the next flag value, so hold and flag rise together
         hard_q <= trap_d[pic_pkg::PIC_TRAP_ADDR]
            | trap_d[pic_pkg::PIC_TRAP_OSC];
   end

   // Wake on any enabled pending flag; core vectors only if vec_req rises
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         wake_q <= 1'b0;
      else
         wake_q <= cpu.sleeping && ((|(flag_q & src_enable_bit))
            || trap_any);
   end

   // CPU level save on entry, restore on return
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cpl_q <= '0;
         sp_q <= '0;
         in_isr_q <= 1'b0;
         active_lvl_q <= '0;
         for (int i = 0; i < pic_pkg::CPL_STACK_DEPTH; i++)
            cpl_stack_q[i] <= '0;
      end
      else if (cpu.vec_ack)
      begin
         cpl_stack_q[sp_q] <= cpl_q;
         sp_q <= sp_q + 4'h1;
         in_isr_q <= 1'b1;
         active_lvl_q <= vec_level_q;
         cpl_q <= vec_level_q[3] ? pic_pkg::PRIO_ALL_MASK
            : vec_level_q[2:0];
      end
      else if (cpu.irq_return && sp_q != '0)
      begin
         cpl_q <= cpl_stack_q[sp_q - 4'h1];
         sp_q <= sp_q - 4'h1;
         in_isr_q <= (sp_q != 4'h1);
         active_lvl_q <= {1'b0, cpl_stack_q[sp_q - 4'h1]};
      end
      else if (cpu.cpl_write)
         cpl_q <= cpu.cpl_wdata;
   end

   assign cpu.vec_req = vec_req_q;
   assign cpu.vec_addr = vec_addr_q;
   assign cpu.vec_level = vec_level_q;
   assign cpu.hard_hold = hard_q;
   assign cpu.wake = wake_q;
   assign cpu.cpu_level = cpl_q;
endmodule : pic_ctrl

// file: rtl/pic_core_end.sv
// Core end: AHB-Lite register slave that drives the controller's link.
// Assumes a single AHB-Lite master, word transfers, same clock.
`timescale 1ns/1ps
module pic_core_end (
   input wire logic ref_clk, // Instruction clock
   input wire logic rst, // Async reset, active high
   pic_if.core cpu, // Controller side
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Always ready
   output logic hresp // Always OKAY
);
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_CPL = 8'h04;
   localparam logic [7:0] A_TDIS = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   localparam logic [7:0] A_VEC = 8'h10;
   logic wr_q;
   logic [7:0] ad_q;
   logic [31:0] rd_q;
   logic ack_q, ret_q, cw_q, ds_q, slp_q;
   logic [2:0] cwd_q;
   logic [13:0] dc_q;
   logic [15:0] last_vec_q;
   logic hs;

   assign hs = hsel && hready && htrans[1];

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         ad_q <= '0;
      end
      else
      begin
         wr_q <= hs && hwrite;
         ad_q <= haddr[7:0];
      end
   end

   // Command strobes: bit0 ack, bit1 return, bit2 sleep level
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
         ret_q <= 1'b0;
         cw_q <= 1'b0;
         ds_q <= 1'b0;
         slp_q <= 1'b0;
         cwd_q <= '0;
         dc_q <= '0;
         last_vec_q <= '0;
      end
      else
      begin
         ack_q <= wr_q && ad_q == A_CMD && hwdata[0] && cpu.vec_req;
         ret_q <= wr_q && ad_q == A_CMD && hwdata[1];
         cw_q <= wr_q && ad_q == A_CPL;
         ds_q <= wr_q && ad_q == A_TDIS;
         if (wr_q && ad_q == A_CMD)
            slp_q <= hwdata[2];
         else if (cpu.wake)
            slp_q <= 1'b0;
         if (wr_q && ad_q == A_CPL)
            cwd_q <= hwdata[2:0];
         if (wr_q && ad_q == A_TDIS)
            dc_q <= hwdata[13:0];
         if (cpu.vec_req)
            last_vec_q <= cpu.vec_addr;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rd_q <= '0;
      else if (hs && !hwrite)
      begin
         case (haddr[7:0])
            A_STAT: rd_q <= {24'h00_0000, cpu.wake, cpu.hard_hold,
               cpu.vec_req, 2'h0, cpu.cpu_level};
            A_VEC: rd_q <= {12'h000, cpu.vec_level, last_vec_q};
            A_CPL: rd_q <= {29'h0000_0000, cpu.cpu_level};
            A_TDIS: rd_q <= {18'h0_0000, dc_q};
            default: rd_q <= '0;
         endcase
      end
   end

   assign hrdata = rd_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cpu.vec_ack = ack_q;
   assign cpu.irq_return = ret_q;
   assign cpu.cpl_write = cw_q;
   assign cpu.cpl_wdata = cwd_q;
   assign cpu.tdis_start = ds_q;
   assign cpu.tdis_count = dc_q;
   assign cpu.sleeping = slp_q;
endmodule : pic_core_end

// file: sim/pic_asserts.sv
// Checker on the link between controller and core end.
// Assumes one clock; placed beside the link in the bench top.
`timescale 1ns/1ps
module pic_asserts (
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic vec_req, // Request
   input wire logic [15:0] vec_addr, // Vector
   input wire logic [3:0] vec_level, // Level
   input wire logic hard_hold, // Hold
   input wire logic vec_ack, // Ack
   input wire logic [2:0] cpu_level, // CPU level
   input wire logic cpl_write, // Level write
   input wire logic [2:0] cpl_wdata, // Level data
   input wire logic tdis_start, // Timed disable
   input wire logic [13:0] tdis_count // Span
);
   logic [2:0] exp_q;
   logic [13:0] dis_q;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // Traps leave the core at level seven
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         exp_q <= 3'h0;
      else
         exp_q <= vec_level[3] ? 3'h7 : vec_level[2:0];
   end
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         dis_q <= 14'h0000;
      else if (tdis_start)
         dis_q <= tdis_count;
      else if (dis_q != 14'h0000)
         dis_q <= dis_q - 14'h0001;
   end
   a_req_holds: assert property (
      vec_req && !vec_ack && !hard_hold |=> vec_req)
      else $error("request dropped before ack");
   a_ack_clears: assert property (
      vec_ack && vec_req |=> !vec_req)
      else $error("request stays after ack");
   a_above_cpl: assert property (
      vec_req && !vec_level[3] |-> vec_level[2:0] > cpu_level)
      else $error("request not above cpu level");
   a_trap_vec: assert property (
      vec_req && vec_level[3] |-> (vec_addr - 16'h0004) < 16'h0008
      || (vec_addr - 16'h0104) < 16'h0008)
      else $error("trap vector outside trap slots");
   a_user_vec: assert property (
      vec_req && !vec_level[3] |-> vec_level != 4'h0 &&
      ((vec_addr - 16'h0014) < 16'h0008 ||
      (vec_addr - 16'h0114) < 16'h0008))
      else $error("bad user vector or level");
   a_cpl_on_ack: assert property (
      vec_ack && vec_req |=> cpu_level == exp_q)
      else $error("cpu level not taken on ack");
   a_cpl_write: assert property (
      cpl_write |=> cpu_level == $past(cpl_wdata))
      else $error("cpu level write lost");
   a_hard_stalls: assert property (
      hard_hold && !vec_req |=> !vec_req)
      else $error("vector raised during hard trap");
   a_tdis_blocks: assert property (
      dis_q > 14'h0002 |-> !vec_req || vec_level[3] || vec_level == 4'h7)
      else $error("request during timed disable");
   c_trap_ack: cover property (vec_ack && vec_req && vec_level[3]);
   c_hard: cover property (hard_hold);
   c_tdis: cover property (dis_q > 14'h0002);
   c_nest: cover property (vec_ack && vec_req && !vec_level[3]
      && cpu_level != 3'h0);
endmodule : pic_asserts

// file: sim/pic_ctrl_tb.sv
// Bench: both ends on one link, core end driven over AHB-Lite.
// Assumes zero wait states and eight sources.
`timescale 1ns/1ps
module pic_ctrl_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sev = 8'h00;
   logic [7:0] tev = 8'h00;
   logic [7:0] src_en = 8'h00;
   logic [23:0] prio = 24'h00_0000;
   logic prio_we = 1'b0;
   logic [7:0] fclr = 8'h00;
   logic [7:0] tclr = 8'h00;
   logic [15:0] ctl_one = 16'h0000;
   logic alt_sel = 1'b0;
   logic [7:0] pend;
   logic [7:0] tflag;
   logic [23:0] prio_rb;
   logic hsel = 1'b1;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] rdat;
   int err_total = 0;
   int checks_done = 0;
   int cyc;
   always #5 ref_clk = ~ref_clk;
   pic_if pic_if_i ();
   pic_ctrl #(.NSRC(8)) pic_ctrl_i (.ref_clk(ref_clk), .rst(rst),
      .cpu(pic_if_i.ctrl), .src_event(sev), .trap_event(tev),
      .src_enable_bit(src_en), .prio_wdata(prio), .prio_we(prio_we),
      .flag_clr(fclr), .trap_clr(tclr), .irq_control_one(ctl_one),
      .alt_table_sel(alt_sel), .source_pending_flag(pend),
      .trap_flag_q(tflag), .source_priority_field(prio_rb));
   pic_core_end pic_core_end_i (.ref_clk(ref_clk), .rst(rst),
      .cpu(pic_if_i.core), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp));
   pic_asserts pic_asserts_i (.ref_clk(ref_clk), .rst(rst),
      .vec_req(pic_if_i.vec_req), .vec_addr(pic_if_i.vec_addr),
      .vec_level(pic_if_i.vec_level), .hard_hold(pic_if_i.hard_hold),
      .vec_ack(pic_if_i.vec_ack), .cpu_level(pic_if_i.cpu_level),
      .cpl_write(pic_if_i.cpl_write), .cpl_wdata(pic_if_i.cpl_wdata),
      .tdis_start(pic_if_i.tdis_start), .tdis_count(pic_if_i.tdis_count));
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1)
         @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1)
         @(posedge ref_clk);
      rdat = hrdata;
      // Strobe lands on the data phase edge, level update one edge after it
      repeat (3)
         @(posedge ref_clk);
   endtask : bus
   task automatic rd(input logic [31:0] a, e, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, rdat);
   endtask : rd
   task automatic ev(input logic [7:0] s, t);
      sev <= s;
      tev <= t;
      @(posedge ref_clk);
      sev <= 8'h00;
      tev <= 8'h00;
   endtask : ev
   task automatic clr(input logic [7:0] f, t);
      fclr <= f;
      tclr <= t;
      @(posedge ref_clk);
      fclr <= 8'h00;
      tclr <= 8'h00;
   endtask : clr
   task automatic wreq(input int n);
      cyc = 0;
      while (pic_if_i.vec_req !== 1'b1 && cyc < n)
      begin
         @(posedge ref_clk);
         cyc++;
      end
   endtask : wreq
   task automatic idle(input int n);
      wreq(n);
      chk("no_req", 32'h0000_0000, {31'h0, pic_if_i.vec_req});
   endtask : idle
   // Trap levels are only known to lie in 8..15
   task automatic serve(input logic [15:0] a, input logic [3:0] l);
      wreq(40);
      chk("vec_req", 32'h0000_0001, {31'h0, pic_if_i.vec_req});
      chk("vec_addr", {16'h0, a}, {16'h0, pic_if_i.vec_addr});
      chk("vec_lvl", {28'h0, l}, {28'h0, l[3] ? pic_if_i.vec_level
         & 4'h8 : pic_if_i.vec_level});
      bus(1'b1, 32'h0000_0000, 32'h0000_0001);
   endtask : serve
   task automatic ret(input logic [31:0] e);
      bus(1'b1, 32'h0000_0000, 32'h0000_0002);
      rd(32'h0000_0004, e, "cpl");
   endtask : ret
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (16)
         @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk("prio", 32'h0092_4924, {8'h00, prio_rb});
      rd(32'h0000_0040, 32'h0000_0000, "unmapped");
      rd(32'h0000_000C, 32'h0000_0000, "status");
      $display("reset test done");
      src_en <= 8'h0F;
      prio <= {12'h000, 3'h6, 3'h5, 3'h2, 3'h0};
      prio_we <= 1'b1;
      @(posedge ref_clk);
      prio_we <= 1'b0;
      ev(8'h07, 8'h00);
      wreq(40);
      chk("latency", 32'h0000_0007, cyc);
      chk("pend", 32'h0000_0007, {24'h0, pend});
      serve(16'h0016, 4'h5);
      rd(32'h0000_0004, 32'h0000_0005, "cpl");
      clr(8'h04, 8'h00);
      idle(20);
      ctl_one <= 16'h8000;
      ev(8'h08, 8'h00);
      idle(20);
      ctl_one <= 16'h0000;
      serve(16'h0017, 4'h6);
      clr(8'h08, 8'h00);
      ret(32'h0000_0005);
      ret(32'h0000_0000);
      serve(16'h0015, 4'h2);
      clr(8'h03, 8'h00);
      ret(32'h0000_0000);
      $display("user test done");
      bus(1'b1, 32'h0000_0004, 32'h0000_0007);
      ev(8'h08, 8'h00);
      idle(20);
      ev(8'h00, 8'h04);
      serve(16'h0006, 4'h8);
      chk("tflag", 32'h0000_0004, {24'h0, tflag});
      clr(8'h00, 8'h04);
      ret(32'h0000_0007);
      alt_sel <= 1'b1;
      ev(8'h00, 8'h08);
      serve(16'h0107, 4'h8);
      clr(8'h00, 8'h08);
      ret(32'h0000_0007);
      alt_sel <= 1'b0;
      for (int t = 0; t < 2; t++)
      begin
         ev(8'h00, 8'h01 << t);
         rd(32'h0000_000C, 32'h0000_0047, "hard_on");
         chk("tflag", 32'h0000_0001 << t, {24'h0, tflag});
         clr(8'h00, 8'h01 << t);
         rd(32'h0000_000C, 32'h0000_0007, "hard_off");
      end
      $display("trap test done");
      bus(1'b1, 32'h0000_0004, 32'h0000_0000);
      serve(16'h0017, 4'h6);
      clr(8'h08, 8'h00);
      ret(32'h0000_0000);
      bus(1'b1, 32'h0000_0008, 32'h0000_001E);
      ev(8'h08, 8'h00);
      idle(12);
      serve(16'h0017, 4'h6);
      clr(8'h08, 8'h00);
      ret(32'h0000_0000);
      // One common level: natural order decides, no nesting
      prio <= {12'h000, 3'h3, 3'h3, 3'h3, 3'h3};
      prio_we <= 1'b1;
      @(posedge ref_clk);
      prio_we <= 1'b0;
      ev(8'h0C, 8'h00);
      serve(16'h0016, 4'h3);
      clr(8'h04, 8'h00);
      ret(32'h0000_0000);
      serve(16'h0017, 4'h3);
      clr(8'h08, 8'h00);
      ret(32'h0000_0000);
      // Wake stands only until the core end leaves sleep
      bus(1'b1, 32'h0000_0004, 32'h0000_0007);
      bus(1'b1, 32'h0000_0000, 32'h0000_0004);
      ev(8'h02, 8'h00);
      repeat (2)
         @(posedge ref_clk);
      chk("wake", 32'h0000_0001, {31'h0, pic_if_i.wake});
      idle(12);
      rd(32'h0000_000C, 32'h0000_0007, "resume");
      bus(1'b1, 32'h0000_0004, 32'h0000_0000);
      wreq(40);
      rd(32'h0000_000C, 32'h0000_0020, "vector");
      serve(16'h0015, 4'h3);
      $display("timed and wake test done");
      test_done();
   end
   initial
   begin
      repeat (5000)
         @(posedge ref_clk);
      err_total++;
      test_done();
   end
endmodule : pic_ctrl_tb
